// >>> pkg/omcs_pkg.sv
// constants and carrier types for the optical module control block
package omcs_pkg;
	localparam int          CLK_MHZ     = 200;
	localparam int          US_DIV_W    = 8;
	localparam int          TW          = 27;
	localparam int          T_RESET_US  = 10;
	localparam int          T_RESET_CYC = T_RESET_US * CLK_MHZ;
	localparam int          HOLD_W      = 12;
	localparam int          AW          = 8;
	localparam logic [7:0]  A_CTRL      = 8'h00;
	localparam logic [7:0]  A_STAT      = 8'h04;
	localparam logic [7:0]  A_IRQ_STAT  = 8'h08;
	localparam logic [7:0]  A_IRQ_CLR   = 8'h0c;
	localparam logic [7:0]  A_IRQ_EN    = 8'h10;
	localparam int          IRQ_W       = 4;
	localparam int          EV_FAULT    = 0;
	localparam int          EV_LOS      = 1;
	localparam int          EV_READY    = 2;
	localparam int          EV_RATE     = 3;
	localparam logic [1:0]  HTRANS_NSEQ = 2'h2;
	typedef struct packed {
		logic fc_rate;
		logic cooled;
		logic pl2_en;
	} omcs_ctrl_t;
	localparam omcs_ctrl_t  CTRL_RST    = '{fc_rate: 1'b0, cooled: 1'b0, pl2_en: 1'b0};
	typedef struct packed {
		logic rate_stable;
		logic pl2_active;
		logic op_ready;
		logic mgmt_ready;
		logic rx_los;
		logic tx_fault;
		logic laser_en;
	} omcs_stat_t;
	localparam logic [IRQ_W-1:0] IRQ_RST = 4'h0;
endpackage

// >>> core/omcs_ctrl.sv
// optical module control and status logic with ahb-lite registers
//
// Overview of operation
// - laser off within 100 us of disable
// - laser back within 2 ms of enable
// - management interface ready within 300 ms
// - non-cooled part operational within 300 ms
// - cooled part operational within 90 s
// - level II entry within 300 ms
// - level II exit within 300 ms
// - fault output asserted within 1/50 ms
// - disable held 10 us clears fault
// - rate select settles in 500us/10ms
// - loss flag set within 100 us
// - loss flag cleared within 100 us
//
// Chosen here: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module omcs_timer
	import omcs_pkg::*;
(
	input  wire logic          clk,
	input  wire logic          rst_n,
	input  wire logic          tick,
	input  wire logic          load,
	input  wire logic [TW-1:0] val,
	output logic               done
);
	logic [TW-1:0] cnt_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= '0;
		end else if (load) begin
			cnt_q <= val;
		end else if (tick && cnt_q != '0) begin
			cnt_q <= cnt_q - TW'(1);
		end
	end
	assign done = (cnt_q == '0) && !load;
endmodule

module omcs_ctrl
	import omcs_pkg::*;
#(
	parameter int T_2W_US    = 300000,
	parameter int T_START_US = 300000,
	parameter int T_COOL_US  = 90000000,
	parameter int T_PL2_US   = 300000,
	parameter int T_PDN_US   = 300000,
	parameter int T_RS_FC_US = 500,
	parameter int T_RS_US    = 10000
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        tx_disable,
	input  wire logic        rate_select_low,
	input  wire logic        rate_select_high,
	input  wire logic        laser_fault,
	input  wire logic        rx_signal_present,
	output logic             laser_en,
	output logic             tx_fault,
	output logic             rx_los,
	output logic             mgmt_ready,
	output logic             op_ready,
	output logic             pl2_active,
	output logic             rate_stable,
	output logic             irq
);
	omcs_ctrl_t          ctrl_q;
	omcs_stat_t          stat;
	logic [IRQ_W-1:0]    ist_q;
	logic [IRQ_W-1:0]    ien_q;
	logic [IRQ_W-1:0]    ev;
	logic [US_DIV_W-1:0] div_q;
	logic                tick;
	logic                wr_q;
	logic [AW-1:0]       wa_q;
	logic                acc;
	logic                wr_ctrl;
	logic                pl2_load;
	logic                boot_q;
	logic                dis_q;
	logic                rsl_q;
	logic                rsh_q;
	logic                los_q;
	logic                st_load;
	logic                st_done;
	logic                pl2_done;
	logic                rs_load;
	logic                rs_done;
	logic [HOLD_W-1:0]   hold_q;
	logic                fault_clr;
	logic                op_prev_q;
	logic                rs_prev_q;

	// one-cycle microsecond tick
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_q <= '0;
		end else if (div_q == US_DIV_W'(CLK_MHZ - 1)) begin
			div_q <= '0;
		end else begin
			div_q <= div_q + US_DIV_W'(1);
		end
	end
	assign tick = (div_q == US_DIV_W'(CLK_MHZ - 1));

	// ahb-lite slave, zero wait states, always okay
	assign acc       = hsel && hready && htrans[1];
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'b0;
			wa_q <= '0;
		end else begin
			wr_q <= acc && hwrite;
			wa_q <= haddr[AW-1:0];
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= '0;
		end else if (acc && !hwrite) begin
			case (haddr[AW-1:0])
				A_CTRL:     hrdata <= 32'(ctrl_q);
				A_STAT:     hrdata <= 32'(stat);
				A_IRQ_STAT: hrdata <= 32'(ist_q);
				A_IRQ_EN:   hrdata <= 32'(ien_q);
				default:    hrdata <= '0;
			endcase
		end
	end
	assign wr_ctrl  = wr_q && (wa_q == A_CTRL);
	// write completion stands in for the stop bit of the management write
	assign pl2_load = wr_ctrl && (hwdata[0] != ctrl_q.pl2_en);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q <= CTRL_RST;
		end else if (wr_ctrl) begin
			ctrl_q <= omcs_ctrl_t'(hwdata[2:0]);
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ien_q <= IRQ_RST;
		end else if (wr_q && wa_q == A_IRQ_EN) begin
			ien_q <= hwdata[IRQ_W-1:0];
		end
	end
	// sticky status: a new event beats a clear in the same cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ist_q <= IRQ_RST;
		end else if (wr_q && wa_q == A_IRQ_CLR) begin
			ist_q <= (ist_q & ~hwdata[IRQ_W-1:0]) | ev;
		end else begin
			ist_q <= ist_q | ev;
		end
	end
	assign irq = |(ist_q & ien_q);

	// power-on flag and edge history of the pins
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			boot_q    <= 1'b1;
			dis_q     <= 1'b1;
			rsl_q     <= 1'b0;
			rsh_q     <= 1'b0;
			op_prev_q <= 1'b0;
			rs_prev_q <= 1'b1;
		end else begin
			boot_q    <= 1'b0;
			dis_q     <= tx_disable;
			rsl_q     <= rate_select_low;
			rsh_q     <= rate_select_high;
			op_prev_q <= op_ready;
			rs_prev_q <= rate_stable;
		end
	end

	// management interface readiness after power-on
	omcs_timer u_tw (
		.clk   (hclk),
		.rst_n (hresetn),
		.tick  (tick),
		.load  (boot_q),
		.val   (TW'(T_2W_US)),
		.done  (mgmt_ready)
	);

	// start-up: power-on, disable negated while starting, fault recovery
	assign st_load = boot_q || (dis_q && !tx_disable && !op_ready) || fault_clr;
	omcs_timer u_st (
		.clk   (hclk),
		.rst_n (hresetn),
		.tick  (tick),
		.load  (st_load),
		.val   (ctrl_q.cooled ? TW'(T_COOL_US) : TW'(T_START_US)),
		.done  (st_done)
	);
	assign op_ready = st_done && !tx_fault;

	// laser drive follows the disable pin on the next clock
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			laser_en <= 1'b0;
		end else begin
			laser_en <= op_ready && !tx_disable && !laser_fault;
		end
	end

	// fault latch and disable-hold reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hold_q <= '0;
		end else if (!tx_disable || fault_clr) begin
			hold_q <= '0;
		end else if (tx_fault) begin
			hold_q <= hold_q + HOLD_W'(1);
		end
	end
	assign fault_clr = tx_fault && tx_disable && (hold_q == HOLD_W'(T_RESET_CYC - 1));
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_fault <= 1'b0;
		end else if (laser_fault) begin
			tx_fault <= 1'b1;
		end else if (fault_clr) begin
			tx_fault <= 1'b0;
		end
	end

	// power level II entry and exit
	omcs_timer u_pl2 (
		.clk   (hclk),
		.rst_n (hresetn),
		.tick  (tick),
		.load  (pl2_load),
		.val   (hwdata[0] ? TW'(T_PL2_US) : TW'(T_PDN_US)),
		.done  (pl2_done)
	);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pl2_active <= 1'b0;
		end else if (pl2_done) begin
			pl2_active <= ctrl_q.pl2_en;
		end
	end

	// rate select settling
	assign rs_load = (rate_select_low && !rsl_q) || (rate_select_high && !rsh_q);
	omcs_timer u_rs (
		.clk   (hclk),
		.rst_n (hresetn),
		.tick  (tick),
		.load  (rs_load),
		.val   (ctrl_q.fc_rate ? TW'(T_RS_FC_US) : TW'(T_RS_US)),
		.done  (rs_done)
	);
	assign rate_stable = rs_done;

	// receive loss flag tracks the detector within a cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_los <= 1'b1;
			los_q  <= 1'b1;
		end else begin
			rx_los <= !rx_signal_present;
			los_q  <= rx_los;
		end
	end

	assign ev[EV_FAULT] = laser_fault && !tx_fault;
	assign ev[EV_LOS]   = rx_los != los_q;
	assign ev[EV_READY] = op_ready && !op_prev_q;
	assign ev[EV_RATE]  = rate_stable && !rs_prev_q;

	assign stat = '{rate_stable: rate_stable, pl2_active: pl2_active,
		op_ready: op_ready, mgmt_ready: mgmt_ready, rx_los: rx_los,
		tx_fault: tx_fault, laser_en: laser_en};

	disable_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(tx_disable) |=> !laser_en)
		else $error("laser still on after disable");
	enable_on_a: assert property (@(posedge hclk) disable iff (!hresetn)
		$fell(tx_disable) && op_ready && !laser_fault |=> laser_en)
		else $error("laser not restored after enable");
	mgmt_stays_a: assert property (@(posedge hclk) disable iff (!hresetn)
		mgmt_ready |=> mgmt_ready)
		else $error("management ready dropped");
	start_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
		st_load |=> !op_ready ##1 !laser_en)
		else $error("operational during start-up");
	pl2_follow_a: assert property (@(posedge hclk) disable iff (!hresetn)
		pl2_done && !$past(pl2_load) |=> pl2_active == $past(ctrl_q.pl2_en))
		else $error("power level not applied");
	pl2_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
		pl2_load |=> $stable(pl2_active))
		else $error("power level moved early");
	fault_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
		laser_fault |=> tx_fault ##1 !laser_en)
		else $error("fault not flagged");
	fault_keep_a: assert property (@(posedge hclk) disable iff (!hresetn)
		tx_fault && !tx_disable |=> tx_fault)
		else $error("fault cleared without disable hold");
	fault_clr_a: assert property (@(posedge hclk) disable iff (!hresetn)
		fault_clr |-> hold_q == HOLD_W'(T_RESET_CYC - 1) ##1 st_done == 1'b0)
		else $error("fault reset timing wrong");
	rate_a: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(rate_select_low) || $rose(rate_select_high) |-> !rate_stable)
		else $error("rate not resettling");
	los_on_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!rx_signal_present |=> rx_los)
		else $error("loss flag late");
	los_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
		rx_signal_present && hresetn |=> !rx_los) // skip the reset-release edge
		else $error("loss flag stuck");
	cv_fault_c: cover property (@(posedge hclk) disable iff (!hresetn) fault_clr);
	cv_pl2_c: cover property (@(posedge hclk) disable iff (!hresetn) $rose(pl2_active));
	cv_irq_c: cover property (@(posedge hclk) disable iff (!hresetn) $rose(irq));
endmodule

`default_nettype wire

// >>> verification/omcs_host_model.sv
// host board model that drives the module control pins
`timescale 1ns/1ps
`default_nettype none

module omcs_host_model
	import omcs_pkg::*;
(
	input  wire logic clk,
	output logic      tx_disable,
	output logic      rate_select_low,
	output logic      rate_select_high
);
	// an open pin reads as disabled, so power up with the laser off
	initial begin
		tx_disable       = 1'b1;
		rate_select_low  = 1'b0;
		rate_select_high = 1'b0;
	end

	task automatic set_dis(input logic v);
		@(posedge clk);
		tx_disable <= v;
	endtask

	// hold disable high for n clocks; the fault only clears after T_RESET_CYC
	task automatic clear_fault(input int n);
		set_dis(1'b1);
		repeat (n) @(posedge clk);
		tx_disable <= 1'b0;
	endtask

	// low first so that every call makes a fresh rising edge
	task automatic rate_pulse(input logic hi);
		@(posedge clk);
		rate_select_low  <= 1'b0;
		rate_select_high <= 1'b0;
		@(posedge clk);
		if (hi) begin
			rate_select_high <= 1'b1;
		end else begin
			rate_select_low <= 1'b1;
		end
	endtask
endmodule

`default_nettype wire

// >>> verification/optical_module_control_status_tb.sv
// self-checking bench for the optical module control block
`timescale 1ns/1ps
`default_nettype none

module optical_module_control_status_tb;
	import omcs_pkg::*;
	localparam int T2W = 3;
	localparam int TST = 5;
	localparam int TCO = 8;
	localparam int TP2 = 4;
	localparam int TPD = 3;
	localparam int TRF = 2;
	localparam int TRS = 6;
	logic        hclk;
	logic        hresetn;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        tx_disable;
	logic        rate_select_low;
	logic        rate_select_high;
	logic        laser_fault;
	logic        rx_signal_present;
	wire [6:0]   st;
	logic        irq;
	logic [31:0] rd;
	int          err_count;
	int          comparisons;

	omcs_ctrl #(.T_2W_US(T2W), .T_START_US(TST), .T_COOL_US(TCO), .T_PL2_US(TP2),
		.T_PDN_US(TPD), .T_RS_FC_US(TRF), .T_RS_US(TRS)) i_omcs_ctrl (
		.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .tx_disable(tx_disable),
		.rate_select_low(rate_select_low), .rate_select_high(rate_select_high),
		.laser_fault(laser_fault), .rx_signal_present(rx_signal_present),
		.laser_en(st[0]), .tx_fault(st[1]), .rx_los(st[2]), .mgmt_ready(st[3]),
		.op_ready(st[4]), .pl2_active(st[5]), .rate_stable(st[6]), .irq(irq));

	omcs_host_model i_omcs_host_model (.clk(hclk), .tx_disable(tx_disable),
		.rate_select_low(rate_select_low), .rate_select_high(rate_select_high));

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", s, e, g);
		end
	endtask

	task automatic rdy();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (hreadyout !== 1'b1) begin
			chk("hreadyout", 32'h1, {31'h0, hreadyout});
			give_verdict();
		end
	endtask

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		htrans <= HTRANS_NSEQ;
		haddr  <= {24'h0, a};
		hwrite <= w;
		rdy();
		htrans <= 2'h0;
		hwdata <= d;
		rdy();
		rd = hrdata;
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask

	task automatic wait_st(input int b, input logic v, input int lim);
		int n;
		n = 0;
		#1;
		while (st[b] !== v && n < lim) begin
			@(posedge hclk);
			#1;
			n++;
		end
		chk($sformatf("status bit %0d", b), {31'h0, v}, {31'h0, st[b]});
		if (st[b] !== v) begin
			give_verdict();
		end
	endtask

	initial begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end

	initial begin
		err_count = 0;
		comparisons = 0;
		hresetn = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0000_0000;
		laser_fault = 1'b0;
		rx_signal_present = 1'b1;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		wait_st(3, 1'b0, 1);
		wait_st(3, 1'b1, (T2W + 2) * CLK_MHZ);
		wait_st(4, 1'b1, (TST + 2) * CLK_MHZ);
		i_omcs_host_model.set_dis(1'b0);
		wait_st(0, 1'b1, 3);
		i_omcs_host_model.set_dis(1'b1);
		wait_st(0, 1'b0, 3);
		i_omcs_host_model.set_dis(1'b0);
		$display("test laser control done");
		bus(1'b1, A_IRQ_EN, 32'h0000_0001);
		bus(1'b1, A_CTRL, 32'h0000_0002);
		@(posedge hclk);
		laser_fault <= 1'b1;
		wait_st(1, 1'b1, 3);
		chk("irq", 32'h1, {31'h0, irq});
		bus(1'b0, A_IRQ_STAT, 32'h0);
		chk("fault event", 32'h1, rd & 32'h0000_0001);
		bus(1'b1, A_IRQ_EN, 32'h0000_0000);
		#1 chk("masked irq", 32'h0, {31'h0, irq});
		bus(1'b1, A_IRQ_CLR, 32'h0000_0001);
		bus(1'b0, A_IRQ_STAT, 32'h0);
		chk("cleared event", 32'h0, rd & 32'h0000_0001);
		laser_fault <= 1'b0;
		i_omcs_host_model.clear_fault(T_RESET_CYC - 10);
		repeat (3) @(posedge hclk);
		wait_st(1, 1'b1, 1);
		i_omcs_host_model.clear_fault(T_RESET_CYC + 5);
		wait_st(1, 1'b0, 5);
		wait_st(4, 1'b1, (TCO + 2) * CLK_MHZ);
		$display("test fault recovery done");
		@(posedge hclk);
		rx_signal_present <= 1'b0;
		wait_st(2, 1'b1, 3);
		@(posedge hclk);
		rx_signal_present <= 1'b1;
		wait_st(2, 1'b0, 3);
		$display("test signal loss done");
		for (int fc = 0; fc < 2; fc++) begin
			bus(1'b1, A_CTRL, fc[0] ? 32'h0000_0004 : 32'h0000_0000);
			for (int p = 0; p < 2; p++) begin
				i_omcs_host_model.rate_pulse(p[0]);
				wait_st(6, 1'b0, 1);
				wait_st(6, 1'b1, ((fc != 0 ? TRF : TRS) + 2) * CLK_MHZ);
			end
		end
		$display("test rate select done");
		bus(1'b1, A_CTRL, 32'h0000_0001);
		bus(1'b0, A_CTRL, 32'h0);
		chk("ctrl readback", 32'h0000_0001, rd);
		wait_st(5, 1'b0, 1);
		wait_st(5, 1'b1, (TP2 + 2) * CLK_MHZ);
		bus(1'b1, A_CTRL, 32'h0000_0000);
		wait_st(5, 1'b0, (TPD + 2) * CLK_MHZ);
		$display("test power level done");
		bus(1'b0, A_IRQ_STAT, 32'h0);
		chk("event flags", 32'h0000_000e, rd);
		bus(1'b0, A_STAT, 32'h0);
		chk("status", 32'h0000_0059, rd);
		bus(1'b0, 8'h20, 32'h0);
		chk("unmapped", 32'h0000_0000, rd);
		$display("test registers done");
		give_verdict();
	end
endmodule

`default_nettype wire
